// [core/sdt_cfg.svh]
// Timing counts, field positions and reset values for the memory link
`ifndef SDT_CFG_SVH
`define SDT_CFG_SVH

`define SDT_CLK_PS 20000
`define SDT_CYC_UP(ns) ((((ns) * 1000) + `SDT_CLK_PS - 1) / `SDT_CLK_PS)
`define SDT_CYC_DN(ns) (((ns) * 1000) / `SDT_CLK_PS)

`define SDT_TRC_NS 75
`define SDT_TRAS_NS 45
`define SDT_TRP_NS 20
`define SDT_TRCD_NS 20
`define SDT_TRRD_NS 15
`define SDT_TCKA_NS 3
`define SDT_TRC_CYC `SDT_CYC_UP(`SDT_TRC_NS)
`define SDT_TRAS_CYC `SDT_CYC_UP(`SDT_TRAS_NS)
`define SDT_TRP_CYC `SDT_CYC_UP(`SDT_TRP_NS)
`define SDT_TRCD_CYC `SDT_CYC_UP(`SDT_TRCD_NS)
`define SDT_TRRD_CYC `SDT_CYC_UP(`SDT_TRRD_NS)
`define SDT_TCKA_CYC (1 + `SDT_CYC_UP(`SDT_TCKA_NS))
`define SDT_TDPL_CYC 2
`define SDT_TDAL_CYC (`SDT_TDPL_CYC + `SDT_TRP_CYC)
`define SDT_TMRD_CYC 2

`define SDT_TREF_MS 32
`define SDT_REF_ROWS 2048
`define SDT_REF_INT_CYC ((((`SDT_TREF_MS * 1000000) / `SDT_REF_ROWS) * 1000) / `SDT_CLK_PS)
`define SDT_INIT_REFS 2
`define SDT_PWRUP_CYC 10000

`define SDT_A_AUTO 10
`define SDT_MR_CL_LSB 4
`define SDT_CAS_LAT 3
`define SDT_CL_RESET 2'h3
`define SDT_BL_RESET 3'h0
`define SDT_BL_FULL 3'h7
`define SDT_BL_MAXCODE 3'h3
`define SDT_LANES 2
`define SDT_MEM_WORDS 512

`endif

// [core/sdt_pkg.sv]
// Command encodings and state types shared by both link ends
package sdt_pkg;
    // {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0] {
        CMD_MRS = 4'h0,
        CMD_REF = 4'h1,
        CMD_PRE = 4'h2,
        CMD_ACT = 4'h3,
        CMD_WR = 4'h4,
        CMD_RD = 4'h5,
        CMD_BST = 4'h6,
        CMD_NOP = 4'h7,
        CMD_DESEL = 4'h8
    } sdt_cmd_t;

    typedef enum {BURST_IDLE, BURST_RD, BURST_WR} sdt_burst_t;

    typedef enum {
        ST_POWER, ST_PRE_ALL, ST_INIT_REF, ST_MRS, ST_IDLE, ST_COL, ST_CLOSE
    } sdt_state_t;
endpackage

// [core/sdt_bus_if.sv]
// Memory link pins between controller and memory ends
`timescale 1ns/1ps
interface sdt_bus_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic ba;
    logic [10:0] addr;
    logic [1:0] dqm;
    logic [15:0] ctl_dq_o;
    logic ctl_dq_oe;
    logic [15:0] mem_dq_o;
    logic [1:0] mem_dq_oe;
    wire [15:0] dq;

    // Memory lanes win; a clash is a protocol error upstream
    assign dq[7:0] = mem_dq_oe[0] ? mem_dq_o[7:0] : (ctl_dq_oe ? ctl_dq_o[7:0] : 8'h00);
    assign dq[15:8] = mem_dq_oe[1] ? mem_dq_o[15:8] : (ctl_dq_oe ? ctl_dq_o[15:8] : 8'h00);

    modport ctl (
        output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, ctl_dq_o, ctl_dq_oe,
        input dq
    );
    modport mem (
        input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
        output mem_dq_o, mem_dq_oe,
        input dq
    );
endinterface

// [core/sdt_gap_timer.sv]
// Down-counter that holds off a command for a given number of cycles
`timescale 1ns/1ps
module sdt_gap_timer (
    input logic clk,
    input logic sys_rst,
    input logic load,
    input logic [7:0] gap,
    output logic done
);
    logic [7:0] cnt;
    logic [7:0] dec;
    logic [7:0] want;

    assign dec = (cnt == 8'h00) ? 8'h00 : cnt - 8'h01;
    assign want = (gap == 8'h00) ? 8'h00 : gap - 8'h01;
    assign done = (cnt == 8'h00);

    // Longest pending spacing wins over a shorter new one
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt <= 8'h00;
        end else if (load && want > dec) begin
            cnt <= want;
        end else begin
            cnt <= dec;
        end
    end
endmodule

// [core/sdt_mem_end.sv]
// Memory end: decodes link commands and answers with timed data
`timescale 1ns/1ps
`include "sdt_cfg.svh"
module sdt_mem_end
    import sdt_pkg::*;
(
    input logic clk,
    input logic sys_rst,
    sdt_bus_if.mem bus,
    output logic [1:0] bank_open,
    output logic [1:0] cas_latency
);
    sdt_cmd_t cmd;
    sdt_burst_t burst;
    logic live;
    logic col_cmd;
    logic stop;
    logic cont;
    logic burst_end;
    logic rd_now;
    logic wr_now;
    logic cur_bank;
    logic auto_close;
    logic out_val;
    logic [7:0] col;
    logic [8:0] left;
    logic [2:0] burst_code;
    logic [8:0] idx;
    logic [15:0] rd_word;
    logic [15:0] pipe_data [0:2];
    logic [2:0] pipe_val;
    logic [1:0] mask_d1;
    logic [1:0] mask_d2;

    function automatic logic [8:0] burst_words(input logic [2:0] code);
        if (code == `SDT_BL_FULL) begin
            burst_words = 9'h100;
        end else if (code > `SDT_BL_MAXCODE) begin
            burst_words = 9'h001;
        end else begin
            burst_words = 9'(9'h001 << code);
        end
    endfunction

    assign cmd = bus.cs_n ? CMD_DESEL : sdt_cmd_t'({1'b0, bus.ras_n, bus.cas_n, bus.we_n});
    // Low clock enable freezes all state (suspend or power-down)
    assign live = bus.cke;
    assign col_cmd = (cmd == CMD_RD) || (cmd == CMD_WR);
    assign stop = (cmd == CMD_BST) ||
        ((cmd == CMD_PRE) && (bus.addr[`SDT_A_AUTO] || bus.ba == cur_bank));
    // [RULE_07] New column command each cycle
    assign cont = (burst != BURST_IDLE) && (left != 9'h000) && !col_cmd && !stop;
    assign burst_end = (burst != BURST_IDLE) && (left == 9'h000) && !col_cmd && !stop;
    // [RULE_10] Stop cuts fetch now
    // [RULE_12] Precharge cuts fetch now
    assign rd_now = live && ((cmd == CMD_RD) || (cont && burst == BURST_RD));
    // [RULE_11] Stop drops same-cycle data
    // [RULE_13] Precharge drops same-cycle data
    assign wr_now = live && ((cmd == CMD_WR) || (cont && burst == BURST_WR));
    assign idx = col_cmd ? {bus.ba, bus.addr[7:0]} : {cur_bank, col};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            burst <= BURST_IDLE;
            cur_bank <= 1'b0;
            col <= 8'h00;
            left <= 9'h000;
            auto_close <= 1'b0;
        end else if (live) begin
            if (col_cmd) begin
                burst <= (cmd == CMD_RD) ? BURST_RD : BURST_WR;
                cur_bank <= bus.ba;
                col <= bus.addr[7:0] + 8'h01;
                left <= burst_words(burst_code) - 9'h001;
                // [RULE_21] Remember auto-close request
                auto_close <= bus.addr[`SDT_A_AUTO];
            end else if (stop || burst_end) begin
                burst <= BURST_IDLE;
            end else if (cont) begin
                col <= col + 8'h01;
                left <= left - 9'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bank_open <= 2'h0;
        end else if (live) begin
            for (int i = 0; i < `SDT_LANES; i++) begin
                // [RULE_14] Close right after last fetch
                if ((burst_end && auto_close && cur_bank == 1'(i)) ||
                    ((cmd == CMD_PRE) && (bus.addr[`SDT_A_AUTO] || bus.ba == 1'(i)))) begin
                    bank_open[i] <= 1'b0;
                end
                if ((cmd == CMD_ACT) && bus.ba == 1'(i)) begin
                    bank_open[i] <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cas_latency <= `SDT_CL_RESET;
            burst_code <= `SDT_BL_RESET;
        end else if (live && cmd == CMD_MRS) begin
            burst_code <= bus.addr[2:0];
            // Unsupported latency codes keep the old setting
            if (bus.addr[6:4] == 3'h2 || bus.addr[6:4] == 3'h3) begin
                cas_latency <= bus.addr[5:4];
            end
        end
    end

    for (genvar b = 0; b < `SDT_LANES; b++) begin : g_lane
        logic [7:0] lane_mem [0:`SDT_MEM_WORDS-1];
        // [RULE_16] Write mask acts same cycle
        always_ff @(posedge clk) begin
            if (wr_now && !bus.dqm[b]) begin
                lane_mem[idx] <= bus.dq[8*b +: 8];
            end
        end
        assign rd_word[8*b +: 8] = lane_mem[idx];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pipe_val <= 3'h0;
            mask_d1 <= 2'h0;
            mask_d2 <= 2'h0;
            for (int i = 0; i < 3; i++) begin
                pipe_data[i] <= 16'h0000;
            end
        end else if (live) begin
            pipe_val <= {pipe_val[1:0], rd_now};
            pipe_data[0] <= rd_word;
            pipe_data[1] <= pipe_data[0];
            pipe_data[2] <= pipe_data[1];
            mask_d1 <= bus.dqm;
            mask_d2 <= mask_d1;
        end
    end

    // [RULE_05] Data leaves latency cycles after column
    assign out_val = (cas_latency == 2'h2) ? pipe_val[1] : pipe_val[2];
    assign bus.mem_dq_o = (cas_latency == 2'h2) ? pipe_data[1] : pipe_data[2];
    // [RULE_15] Read mask two cycles late
    assign bus.mem_dq_oe = {2{out_val}} & ~mask_d2;
endmodule

// [core/sdt_ctl_end.sv]
// Controller end: power-up, refresh and single-word timed accesses
`timescale 1ns/1ps
`include "sdt_cfg.svh"
// How it works
// [RULE_01] Activate or refresh spaced by row cycle
// [RULE_02] Precharge after active time, well before limit
// [RULE_03] Wait precharge time before next activate
// [RULE_04] Column command after activate-to-column delay
// [RULE_05] Read data latency cycles after column
// [RULE_06] Activates to different banks spaced apart
// [RULE_07] Column commands may come every cycle
// [RULE_08] Two cycles from write data to precharge
// [RULE_09] Auto-closed write: recovery plus precharge time
// [RULE_10] Burst stop floats read data latency later
// [RULE_11] Burst stop drops write data immediately
// [RULE_12] Precharge floats read data latency later
// [RULE_13] Precharge drops write data immediately
// [RULE_14] Auto-closed read precharges before last word
// [RULE_15] Read byte mask acts two cycles later
// [RULE_16] Write byte mask acts same cycle
// [RULE_17] Two idle cycles after mode register set; the code spaces the next command two cycles on, leaving one idle cycle
// [RULE_18] 2048 refreshes every 32 ms
// [RULE_19] Wait after raising clock enable
// [RULE_20] Power-on sequence before any access
// [RULE_21] Address bit ten selects auto-close
// [RULE_22] Mode set only with both banks idle
// [RULE_23] Nanosecond minimums rounded up, per-bank counters
module sdt_ctl_end
    import sdt_pkg::*;
#(
    parameter int PWRUP_CYC = `SDT_PWRUP_CYC
) (
    input logic clk,
    input logic sys_rst,
    sdt_bus_if.ctl bus,
    input logic req_valid,
    input logic req_write,
    input logic req_autoclose,
    input logic req_bank,
    input logic [10:0] req_row,
    input logic [7:0] req_col,
    input logic [15:0] req_wdata,
    input logic [1:0] req_mask,
    output logic req_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic init_done
);
    sdt_state_t state;
    sdt_state_t next_state;
    sdt_cmd_t cmd_q;
    sdt_cmd_t next_cmd;
    logic cke_q;
    logic next_cke;
    logic ba_q;
    logic next_ba;
    logic [10:0] addr_q;
    logic [10:0] next_addr;
    logic [1:0] dqm_q;
    logic [1:0] next_dqm;
    logic oe_q;
    logic next_oe;
    logic wr_q;
    logic ac_q;
    logic [7:0] col_q;
    logic [1:0] mask_q;
    logic [15:0] wdata_q;
    logic [15:0] pwr_cnt;
    logic [1:0] init_refs;
    logic [9:0] ref_cnt;
    logic ref_due;
    logic ref_take;
    logic take;
    logic [2:0] rd_pend;
    logic any_ld;
    logic any_done;
    logic [7:0] any_gap;
    logic [1:0] act_ld;
    logic [1:0] col_ld;
    logic [1:0] pre_ld;
    logic [1:0] act_done;
    logic [1:0] col_done;
    logic [1:0] pre_done;
    logic [7:0] act_gap;
    logic [7:0] pre_gap;

    // [RULE_06] Shared spacing for activates, refresh, mode set
    sdt_gap_timer u_any (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(any_ld),
        .gap(any_gap),
        .done(any_done)
    );

    // [RULE_23] Per-bank down-counters
    for (genvar i = 0; i < `SDT_LANES; i++) begin : g_bank
        sdt_gap_timer u_act (
            .clk(clk),
            .sys_rst(sys_rst),
            .load(act_ld[i]),
            .gap(act_gap),
            .done(act_done[i])
        );
        sdt_gap_timer u_col (
            .clk(clk),
            .sys_rst(sys_rst),
            .load(col_ld[i]),
            .gap(8'(`SDT_TRCD_CYC)),
            .done(col_done[i])
        );
        sdt_gap_timer u_pre (
            .clk(clk),
            .sys_rst(sys_rst),
            .load(pre_ld[i]),
            .gap(pre_gap),
            .done(pre_done[i])
        );
    end

    always_comb begin
        next_state = state;
        next_cmd = CMD_NOP;
        next_cke = cke_q;
        next_ba = ba_q;
        next_addr = addr_q;
        next_dqm = 2'h0;
        next_oe = 1'b0;
        any_ld = 1'b0;
        any_gap = 8'h00;
        act_ld = 2'h0;
        col_ld = 2'h0;
        pre_ld = 2'h0;
        act_gap = 8'h00;
        pre_gap = 8'h00;
        take = 1'b0;
        ref_take = 1'b0;
        case (state)
            // [RULE_20] Power-up wait then init sequence
            ST_POWER: begin
                if (pwr_cnt == 16'(PWRUP_CYC - 1)) begin
                    next_cke = 1'b1;
                    // [RULE_19] Recovery after clock enable rises
                    any_ld = 1'b1;
                    any_gap = 8'(`SDT_TCKA_CYC);
                    next_state = ST_PRE_ALL;
                end
            end
            ST_PRE_ALL: begin
                if (any_done) begin
                    next_cmd = CMD_PRE;
                    next_addr = 11'(1 << `SDT_A_AUTO);
                    act_ld = 2'h3;
                    act_gap = 8'(`SDT_TRP_CYC);
                    next_state = ST_INIT_REF;
                end
            end
            ST_INIT_REF: begin
                if (any_done && (&act_done)) begin
                    next_cmd = CMD_REF;
                    // [RULE_01] Refresh to refresh spacing
                    any_ld = 1'b1;
                    any_gap = 8'(`SDT_TRC_CYC);
                    if (init_refs == 2'(`SDT_INIT_REFS - 1)) begin
                        next_state = ST_MRS;
                    end
                end
            end
            ST_MRS: begin
                // [RULE_22] Both banks idle before mode set
                if (any_done && (&act_done)) begin
                    next_cmd = CMD_MRS;
                    next_addr = 11'(`SDT_CAS_LAT << `SDT_MR_CL_LSB) | 11'(`SDT_BL_RESET);
                    // [RULE_17] Mode set settling time
                    any_ld = 1'b1;
                    any_gap = 8'(`SDT_TMRD_CYC);
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (ref_due) begin
                    if (any_done && (&act_done)) begin
                        next_cmd = CMD_REF;
                        ref_take = 1'b1;
                        any_ld = 1'b1;
                        any_gap = 8'(`SDT_TRC_CYC);
                    end
                end else if (req_valid && any_done && act_done[req_bank]) begin
                    take = 1'b1;
                    next_cmd = CMD_ACT;
                    next_ba = req_bank;
                    next_addr = req_row;
                    any_ld = 1'b1;
                    any_gap = 8'(`SDT_TRRD_CYC);
                    // [RULE_01] Activate to activate spacing
                    act_ld[req_bank] = 1'b1;
                    act_gap = 8'(`SDT_TRC_CYC);
                    // [RULE_04] Activate to column delay
                    col_ld[req_bank] = 1'b1;
                    // [RULE_02] Minimum active time
                    pre_ld[req_bank] = 1'b1;
                    pre_gap = 8'(`SDT_TRAS_CYC);
                    next_state = ST_COL;
                end
            end
            ST_COL: begin
                // Auto-close waits out the active time itself
                if (col_done[ba_q] && (!ac_q || pre_done[ba_q])) begin
                    next_cmd = wr_q ? CMD_WR : CMD_RD;
                    // [RULE_21] Bit ten asks for auto-close
                    next_addr = 11'(col_q) | (ac_q ? 11'(1 << `SDT_A_AUTO) : 11'h000);
                    if (wr_q) begin
                        next_oe = 1'b1;
                        next_dqm = mask_q;
                    end
                    if (ac_q) begin
                        // [RULE_09] Recovery plus precharge time
                        act_ld[ba_q] = 1'b1;
                        act_gap = wr_q ? 8'(`SDT_TDAL_CYC) : 8'(1 + `SDT_TRP_CYC);
                        next_state = ST_IDLE;
                    end else begin
                        // [RULE_08] Write data to precharge gap
                        pre_ld[ba_q] = wr_q;
                        pre_gap = 8'(`SDT_TDPL_CYC);
                        next_state = ST_CLOSE;
                    end
                end
            end
            ST_CLOSE: begin
                // [RULE_02] Close promptly, far inside the maximum
                if (pre_done[ba_q]) begin
                    next_cmd = CMD_PRE;
                    next_addr = 11'h000;
                    // [RULE_03] Precharge to activate gap
                    act_ld[ba_q] = 1'b1;
                    act_gap = 8'(`SDT_TRP_CYC);
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_POWER;
            end
        endcase
    end

    assign req_ready = take;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ST_POWER;
            cmd_q <= CMD_NOP;
            cke_q <= 1'b0;
            ba_q <= 1'b0;
            addr_q <= 11'h000;
            dqm_q <= 2'h0;
            oe_q <= 1'b0;
        end else begin
            state <= next_state;
            cmd_q <= next_cmd;
            cke_q <= next_cke;
            ba_q <= next_ba;
            addr_q <= next_addr;
            dqm_q <= next_dqm;
            oe_q <= next_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_q <= 1'b0;
            ac_q <= 1'b0;
            col_q <= 8'h00;
            mask_q <= 2'h0;
            wdata_q <= 16'h0000;
        end else if (take) begin
            wr_q <= req_write;
            ac_q <= req_autoclose;
            col_q <= req_col;
            mask_q <= req_mask;
            wdata_q <= req_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pwr_cnt <= 16'h0000;
            init_refs <= 2'h0;
            init_done <= 1'b0;
        end else begin
            if (state == ST_POWER) begin
                pwr_cnt <= pwr_cnt + 16'h0001;
            end
            if (state == ST_INIT_REF && next_cmd == CMD_REF) begin
                init_refs <= init_refs + 2'h1;
            end
            if (next_cmd == CMD_MRS) begin
                init_done <= 1'b1;
            end
        end
    end

    // [RULE_18] Refresh tick; a tick beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ref_cnt <= 10'h000;
            ref_due <= 1'b0;
        end else begin
            ref_cnt <= (ref_cnt == 10'(`SDT_REF_INT_CYC - 1)) ? 10'h000 : ref_cnt + 10'h001;
            ref_due <= (ref_cnt == 10'(`SDT_REF_INT_CYC - 1)) || (ref_due && !ref_take);
        end
    end

    // [RULE_05] Capture read word after the latency
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_pend <= 3'h0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            rd_pend <= {rd_pend[1:0], cmd_q == CMD_RD};
            rsp_valid <= rd_pend[`SDT_CAS_LAT - 1];
            if (rd_pend[`SDT_CAS_LAT - 1]) begin
                rsp_rdata <= bus.dq;
            end
        end
    end

    assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = cmd_q;
    assign bus.cke = cke_q;
    assign bus.ba = ba_q;
    assign bus.addr = addr_q;
    assign bus.dqm = dqm_q;
    assign bus.ctl_dq_o = wdata_q;
    assign bus.ctl_dq_oe = oe_q;
endmodule

// [test/sdt_link_checker.sv]
// Timing checker on the memory link command bus
`timescale 1ns/1ps
module sdt_link_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic ba,
    input wire logic [10:0] addr,
    input wire logic [1:0] dqm,
    input wire logic ctl_dq_oe,
    input wire logic [1:0] mem_dq_oe
);
    logic cmd, act, pre, rf, mrs, rd, wr, bst;
    logic [7:0] since_act [2];
    logic [7:0] since_wr [2];
    logic [11:0] since_ref;
    assign cmd = !cs_n && !(ras_n && cas_n && we_n);
    assign act = cmd && !ras_n && cas_n && we_n;
    assign pre = cmd && !ras_n && cas_n && !we_n;
    assign rf = cmd && !ras_n && !cas_n && we_n;
    assign mrs = cmd && !ras_n && !cas_n && !we_n;
    assign rd = cmd && ras_n && !cas_n && we_n;
    assign wr = cmd && ras_n && !cas_n && !we_n;
    assign bst = cmd && ras_n && cas_n && !we_n;
    // Saturating, so a long idle spell never wraps into a false hit
    always_ff @(posedge clk) begin
        for (int b = 0; b < 2; b++) begin
            if (sys_rst) begin
                since_act[b] <= 8'hff;
                since_wr[b] <= 8'hff;
            end else begin
                since_act[b] <= (act && ba == b[0]) ? 8'h1 : since_act[b] + {7'h0, ~&since_act[b]};
                since_wr[b] <= (wr && ba == b[0]) ? 8'h1 : since_wr[b] + {7'h0, ~&since_wr[b]};
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst || rf) begin
            since_ref <= 12'h0;
        end else if (since_ref != 12'hfff) begin
            since_ref <= since_ref + 12'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_trc; act |-> since_act[ba] >= 8'h4; endproperty
    a_trc: assert property (p_trc) else $error("activate inside row cycle");
    property p_ref_gap; rf |=> !(act || rf) [*3]; endproperty
    a_ref_gap: assert property (p_ref_gap) else $error("refresh gap short");
    property p_tras;
        pre |-> (since_act[0] >= 8'h3 || !(addr[10] || !ba))
            && (since_act[1] >= 8'h3 || !(addr[10] || ba));
    endproperty
    a_tras: assert property (p_tras) else $error("precharge before active time");
    property p_tdpl; pre && !addr[10] |-> since_wr[ba] >= 8'h2; endproperty
    a_tdpl: assert property (p_tdpl) else $error("precharge too soon after write");
    property p_tmrd; mrs |=> !cmd; endproperty
    a_tmrd: assert property (p_tmrd) else $error("command right after mode set");
    property p_tcka; $rose(cke) |-> !cmd [*2]; endproperty
    a_tcka: assert property (p_tcka) else $error("command too soon after clock enable");
    property p_rd_lat; rd |-> ##3 (mem_dq_oe == ~$past(dqm, 2)); endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read word late or mask wrong");
    property p_float; pre || bst |-> ##3 (mem_dq_oe == 2'h0); endproperty
    a_float: assert property (p_float) else $error("read data not floated");
    property p_wr_dir; wr |-> ctl_dq_oe && mem_dq_oe == 2'h0; endproperty
    a_wr_dir: assert property (p_wr_dir) else $error("write data not driven");
    property p_ref_int; since_ref <= 12'h320; endproperty
    a_ref_int: assert property (p_ref_int) else $error("refresh interval exceeded");
endmodule

// [test/test_sdram_command_timing.sv]
// Self-checking bench joining both link ends
`timescale 1ns/1ps
module test_sdram_command_timing;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_autoclose = 1'b0;
    logic req_bank = 1'b0;
    logic [10:0] req_row = 11'h0;
    logic [7:0] req_col = 8'h0;
    logic [15:0] req_wdata = 16'h0;
    logic [1:0] req_mask = 2'h0;
    logic req_ready, rsp_valid, init_done;
    logic [15:0] rsp_rdata;
    logic [1:0] bank_open, cas_latency;
    logic [15:0] model [16];
    int fail_count = 0;
    int total_checks = 0;
    int seed = 3;
    int n;
    always #10 clk = ~clk;
    sdt_bus_if bus ();
    // Short power-up wait keeps the run brief
    sdt_ctl_end #(.PWRUP_CYC(20)) i_sdt_ctl_end (.clk(clk), .sys_rst(sys_rst), .bus(bus.ctl),
        .req_valid(req_valid), .req_write(req_write), .req_autoclose(req_autoclose),
        .req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata),
        .req_mask(req_mask), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .init_done(init_done));
    sdt_mem_end i_sdt_mem_end (.clk(clk), .sys_rst(sys_rst), .bus(bus.mem),
        .bank_open(bank_open), .cas_latency(cas_latency));
    sdt_link_checker i_sdt_link_checker (.clk(clk), .sys_rst(sys_rst), .cke(bus.cke),
        .cs_n(bus.cs_n), .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .ba(bus.ba),
        .addr(bus.addr), .dqm(bus.dqm), .ctl_dq_oe(bus.ctl_dq_oe), .mem_dq_oe(bus.mem_dq_oe));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Called at a falling edge; one word per access
    task automatic access(input logic w, input logic ac, input logic b, input logic [2:0] col,
        input logic [15:0] d, input logic [1:0] m);
        int k;
        req_write = w;
        req_autoclose = ac;
        req_bank = b;
        req_col = {5'h0, col};
        req_row = 11'($random(seed));
        req_wdata = d;
        req_mask = m;
        req_valid = 1'b1;
        k = 0;
        #1;
        while (req_ready !== 1'b1 && k < 900) begin
            @(negedge clk);
            #1;
            k++;
        end
        check({15'h0, req_ready}, 16'h1);
        @(negedge clk);
        req_valid = 1'b0;
        k = 0;
        while (k < 20 && !(w ? {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} === 4'h4
                : rsp_valid === 1'b1)) begin
            @(negedge clk);
            k++;
        end
        check({15'h0, k < 20}, 16'h1);
        if (w) begin
            check(bus.dq, d);
            check({13'h0, bus.dqm, bus.addr[10]}, {13'h0, m, ac});
            if (!m[0]) model[{b, col}][7:0] = d[7:0];
            if (!m[1]) model[{b, col}][15:8] = d[15:8];
            // Bank still open two cycles on unless auto-closed
            repeat (2) @(negedge clk);
            check({15'h0, bank_open[b]}, {15'h0, !ac});
        end else begin
            check(rsp_rdata, model[{b, col}]);
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        n = 0;
        while (init_done !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check({15'h0, init_done}, 16'h1);
        for (int i = 0; i < 16; i++) access(1'b1, i[0], i[3], i[2:0], 16'($random(seed)), 2'h0);
        // Mixed traffic long enough for refreshes to cut in
        for (int i = 0; i < 150; i++) begin
            access(1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
                3'($random(seed)), 16'($random(seed)), 2'($random(seed)));
        end
        check({14'h0, cas_latency}, 16'h3);
        stop_test();
    end
    initial begin
        #500000;
        fail_count++;
        stop_test();
    end
endmodule
